// *** fxil_issue_ctrl.sv ***
// Issue routing, microcode expansion and result-latency scoreboard for integer ops
// Operation
// - Overflow recording divides run unpipelined; integer unit takes nothing until done.
// - Overflow recording divide expands to a divide, then a condition-setting compare.
// - Recording count-leading-zeros forms are flagged microcoded and sequenced, not issued directly.
// - Shift-right-algebraic-immediate: integer unit, result after 2 cycles, one every 2 cycles.
// - Moves to return-address and count registers: branch unit, latency 1, every cycle except during recording divide and count-zeros sequences.
// - Word divide takes 10 to 38 cycles from leading-digit counts.
// - Overflowing divide finishes in exactly 10 cycles.
module fxil_issue_ctrl (
	input  wire logic                         I_REF_CLK,
	input  wire logic                         I_RST,
	input  wire logic                         I_ISSUE_VALID,
	input  wire logic [fxil_pkg::OP_W-1:0]    I_ISSUE_OP,
	input  wire logic [fxil_pkg::TAG_W-1:0]   I_ISSUE_DEST,
	input  wire logic [fxil_pkg::TAG_W-1:0]   I_ISSUE_SRC_A,
	input  wire logic [fxil_pkg::TAG_W-1:0]   I_ISSUE_SRC_B,
	input  wire logic [fxil_pkg::LEAD_W-1:0]  I_DIV_RA_LEAD,
	input  wire logic [fxil_pkg::LEAD_W-1:0]  I_DIV_RB_LEAD,
	input  wire logic                         I_DIV_OVERFLOW,
	output logic                              O_ISSUE_READY,
	output logic                              O_UOP_VALID,
	output logic      [fxil_pkg::KIND_W-1:0]  O_UOP_KIND,
	output logic                              O_UOP_TO_BRANCH,
	output logic      [fxil_pkg::TAG_W-1:0]   O_UOP_DEST,
	output logic      [fxil_pkg::LAT_W-1:0]   O_UOP_LATENCY,
	output logic                              O_MICROCODED_FLAG,
	output logic                              O_PIPELINED,
	output logic                              O_INT_BUSY,
	output logic                              O_DIV_DONE
);

	// ==========================================================================
	// Opcode decode
	logic                        d_known;
	logic                        d_branch;
	logic                        d_mc;
	logic                        d_pipe;
	logic                        d_div;
	logic                        d_dword;
	logic                        d_shift;
	logic                        d_clz_rec;
	logic [fxil_pkg::KIND_W-1:0] d_kind;
	logic [fxil_pkg::LAT_W-1:0]  d_lat;

	always_comb begin
		d_known = 1'b1;
		d_branch = 1'b0;
		d_mc = 1'b0;
		d_pipe = 1'b1;
		d_div = 1'b0;
		d_dword = 1'b0;
		d_shift = 1'b0;
		d_clz_rec = 1'b0;
		d_kind = fxil_pkg::UOP_ALU;
		d_lat = fxil_pkg::LAT_GPR;
		case (I_ISSUE_OP)
			fxil_pkg::OP_COMPARE: begin
				d_kind = fxil_pkg::UOP_COMPARE;
				d_lat = fxil_pkg::LAT_COMPARE;
			end
			fxil_pkg::OP_LOGICAL, fxil_pkg::OP_EXT_SIGN, fxil_pkg::OP_ROTATE: begin
				d_kind = fxil_pkg::UOP_ALU;
			end
			fxil_pkg::OP_CLZ_WORD, fxil_pkg::OP_CLZ_DWORD: begin
				d_kind = fxil_pkg::UOP_CLZ;
			end
			fxil_pkg::OP_SRA_IMM_WORD, fxil_pkg::OP_SRA_IMM_DWORD: begin
				d_kind = fxil_pkg::UOP_SHIFT;
				d_shift = 1'b1;
			end
			fxil_pkg::OP_MOVE_TO_RETURN, fxil_pkg::OP_MOVE_TO_COUNT: begin
				d_kind = fxil_pkg::UOP_MOVE;
				d_branch = 1'b1;
				d_lat = fxil_pkg::LAT_MOVE;
			end
			fxil_pkg::OP_DIV_WORD, fxil_pkg::OP_DIV_DWORD: begin
				d_kind = fxil_pkg::UOP_DIVIDE;
				d_div = 1'b1;
				d_pipe = 1'b0;
				d_dword = (I_ISSUE_OP == fxil_pkg::OP_DIV_DWORD);
			end
			fxil_pkg::OP_DIVO_REC_WORD, fxil_pkg::OP_DIVO_REC_DWORD: begin
				d_kind = fxil_pkg::UOP_DIVIDE;
				d_div = 1'b1;
				d_mc = 1'b1;
				d_pipe = 1'b0;
				d_dword = (I_ISSUE_OP == fxil_pkg::OP_DIVO_REC_DWORD);
			end
			fxil_pkg::OP_CLZ_REC_WORD, fxil_pkg::OP_CLZ_REC_DWORD: begin
				d_kind = fxil_pkg::UOP_CLZ;
				d_mc = 1'b1;
				d_clz_rec = 1'b1;
			end
			default: begin
				d_known = 1'b0;
			end
		endcase
	end

	// ==========================================================================
	// Divide timer
	logic                       div_start;
	logic                       div_done;
	logic [fxil_pkg::LAT_W-1:0] div_cycles;

	fxil_div_timer u_div_timer (
		.i_clk      (I_REF_CLK),
		.i_rst      (I_RST),
		.i_start    (div_start),
		.i_dword    (d_dword),
		.i_overflow (I_DIV_OVERFLOW),
		.i_ra_lead  (I_DIV_RA_LEAD),
		.i_rb_lead  (I_DIV_RB_LEAD),
		.o_cycles   (div_cycles),
		.o_busy     (),
		.o_done     (div_done)
	);

	// ==========================================================================
	// Scoreboard: one countdown per result tag
	logic [fxil_pkg::LAT_W-1:0] pend_reg [fxil_pkg::NUM_TAGS];
	logic [fxil_pkg::LAT_W-1:0] pend_next [fxil_pkg::NUM_TAGS];
	logic                       sb_set;
	logic [fxil_pkg::TAG_W-1:0] sb_tag;
	logic [fxil_pkg::LAT_W-1:0] sb_lat;
	logic                       src_a_ok;
	logic                       src_b_ok;

	genvar g;
	generate
		for (g = 0; g < fxil_pkg::NUM_TAGS; g++) begin : g_pend
			always_comb begin
				if (sb_set && (sb_tag == fxil_pkg::TAG_W'(g))) begin
					pend_next[g] = sb_lat;
				end else if (pend_reg[g] != 7'h00) begin
					pend_next[g] = pend_reg[g] - 7'h01;
				end else begin
					pend_next[g] = 7'h00;
				end
			end

			always_ff @(posedge I_REF_CLK) begin
				if (I_RST) begin
					pend_reg[g] <= fxil_pkg::LAT_PEND_RST;
				end else begin
					pend_reg[g] <= pend_next[g];
				end
			end
		end
	endgenerate

	// Tags outside the table never produce a hazard
	// A count of one means the result is usable at the coming edge, so a
	// dependent issues exactly the listed latency after its producer
	always_comb begin
		src_a_ok = (I_ISSUE_SRC_A >= 6'(fxil_pkg::NUM_TAGS)) || (pend_reg[I_ISSUE_SRC_A] <= 7'h01);
		src_b_ok = (I_ISSUE_SRC_B >= 6'(fxil_pkg::NUM_TAGS)) || (pend_reg[I_ISSUE_SRC_B] <= 7'h01);
	end

	// ==========================================================================
	// Sequencer and issue acceptance
	fxil_pkg::fxil_state_t      state_reg;
	fxil_pkg::fxil_state_t      state_next;
	logic                       rec_reg;
	logic                       rec_next;
	logic                       wait_reg;
	logic                       wait_next;
	logic                       shift_gap_reg;
	logic                       shift_gap_next;
	logic                       accept;
	logic                       uop_valid_next;
	logic [fxil_pkg::KIND_W-1:0] uop_kind_next;
	logic                       uop_branch_next;
	logic [fxil_pkg::TAG_W-1:0] uop_dest_next;
	logic [fxil_pkg::LAT_W-1:0] uop_lat_next;
	logic                       uop_mc_next;
	logic                       uop_pipe_next;

	always_comb begin
		O_ISSUE_READY = 1'b0;
		if (d_known && src_a_ok && src_b_ok) begin
			case (state_reg)
				fxil_pkg::ST_IDLE: O_ISSUE_READY = !(d_shift && shift_gap_reg);
				// Branch moves may slip past a plain divide; microcode owns issue
				fxil_pkg::ST_DIV:  O_ISSUE_READY = !rec_reg && d_branch;
				default:           O_ISSUE_READY = 1'b0;
			endcase
		end
	end

	assign accept    = I_ISSUE_VALID && O_ISSUE_READY;
	assign div_start = accept && d_div;

	always_comb begin
		state_next = state_reg;
		rec_next = rec_reg;
		wait_next = wait_reg;
		shift_gap_next = 1'b0;
		uop_valid_next = 1'b0;
		uop_kind_next = O_UOP_KIND;
		uop_branch_next = O_UOP_TO_BRANCH;
		uop_dest_next = O_UOP_DEST;
		uop_lat_next = O_UOP_LATENCY;
		uop_mc_next = O_MICROCODED_FLAG;
		uop_pipe_next = O_PIPELINED;
		sb_set = 1'b0;
		sb_tag = I_ISSUE_DEST;
		sb_lat = d_div ? div_cycles : d_lat;
		if (accept) begin
			uop_valid_next = 1'b1;
			uop_kind_next = d_kind;
			uop_branch_next = d_branch;
			uop_dest_next = I_ISSUE_DEST;
			uop_lat_next = sb_lat;
			uop_mc_next = d_mc;
			uop_pipe_next = d_pipe;
			sb_set = 1'b1;
			shift_gap_next = d_shift && (fxil_pkg::LAT_GPR > 7'h01);
			if (d_div) begin
				state_next = fxil_pkg::ST_DIV;
				rec_next = d_mc;
			end else if (d_clz_rec) begin
				state_next = fxil_pkg::ST_WAIT;
				wait_next = 1'b1;
			end
		end
		case (state_reg)
			fxil_pkg::ST_DIV: begin
				if (div_done) begin
					state_next = fxil_pkg::ST_IDLE;
					if (rec_reg) begin
						uop_valid_next = 1'b1;
						uop_kind_next = fxil_pkg::UOP_COMPARE;
						uop_branch_next = 1'b0;
						uop_dest_next = fxil_pkg::TAG_COND;
						uop_lat_next = fxil_pkg::LAT_COMPARE;
						uop_mc_next = 1'b1;
						uop_pipe_next = 1'b1;
						sb_set = 1'b1;
						sb_tag = fxil_pkg::TAG_COND;
						sb_lat = fxil_pkg::LAT_COMPARE;
					end
				end
			end
			fxil_pkg::ST_WAIT: begin
				// Compare waits for the count result to become usable
				wait_next = 1'b0;
				if (!wait_reg) begin
					state_next = fxil_pkg::ST_IDLE;
					uop_valid_next = 1'b1;
					uop_kind_next = fxil_pkg::UOP_COMPARE;
					uop_branch_next = 1'b0;
					uop_dest_next = fxil_pkg::TAG_COND;
					uop_lat_next = fxil_pkg::LAT_COMPARE;
					uop_mc_next = 1'b1;
					uop_pipe_next = 1'b1;
					sb_set = 1'b1;
					sb_tag = fxil_pkg::TAG_COND;
					sb_lat = fxil_pkg::LAT_COMPARE;
				end
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			state_reg <= fxil_pkg::ST_IDLE;
			rec_reg <= 1'b0;
			wait_reg <= 1'b0;
			shift_gap_reg <= 1'b0;
			O_UOP_VALID <= 1'b0;
			O_UOP_KIND <= fxil_pkg::UOP_ALU;
			O_UOP_TO_BRANCH <= 1'b0;
			O_UOP_DEST <= 6'h00;
			O_UOP_LATENCY <= 7'h00;
			O_MICROCODED_FLAG <= 1'b0;
			O_PIPELINED <= 1'b0;
			O_DIV_DONE <= 1'b0;
		end else begin
			state_reg <= state_next;
			rec_reg <= rec_next;
			wait_reg <= wait_next;
			shift_gap_reg <= shift_gap_next;
			O_UOP_VALID <= uop_valid_next;
			O_UOP_KIND <= uop_kind_next;
			O_UOP_TO_BRANCH <= uop_branch_next;
			O_UOP_DEST <= uop_dest_next;
			O_UOP_LATENCY <= uop_lat_next;
			O_MICROCODED_FLAG <= uop_mc_next;
			O_PIPELINED <= uop_pipe_next;
			O_DIV_DONE <= div_done && (state_reg == fxil_pkg::ST_DIV);
		end
	end

	assign O_INT_BUSY = (state_reg != fxil_pkg::ST_IDLE);

	// ==========================================================================
	// Checks
	AST_DIV_BLOCKS_INT: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		(state_reg == fxil_pkg::ST_DIV && !d_branch) |-> !O_ISSUE_READY)
		else $error("integer op accepted during divide");
	AST_REC_DIV_UOPS: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		(accept && d_div && d_mc) |=> O_UOP_VALID && O_UOP_KIND == fxil_pkg::UOP_DIVIDE
			&& O_MICROCODED_FLAG && !O_PIPELINED ##[10:70] O_UOP_VALID
			&& O_UOP_KIND == fxil_pkg::UOP_COMPARE && O_UOP_DEST == fxil_pkg::TAG_COND)
		else $error("recording divide not expanded into divide and compare");
	AST_CLZ_REC_SEQ: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		(accept && d_clz_rec) |=> (O_UOP_KIND == fxil_pkg::UOP_CLZ && O_MICROCODED_FLAG)
			##2 (O_UOP_VALID && O_UOP_KIND == fxil_pkg::UOP_COMPARE && O_MICROCODED_FLAG))
		else $error("recording count-zeros not sequenced");
	AST_SHIFT_LAT: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		(accept && d_shift) |=> O_UOP_KIND == fxil_pkg::UOP_SHIFT && O_UOP_LATENCY == 7'h02
			&& !O_UOP_TO_BRANCH && !(accept && d_shift))
		else $error("shift latency or issue spacing wrong");
	AST_MOVE_BRANCH: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		(accept && d_kind == fxil_pkg::UOP_MOVE) |=> O_UOP_TO_BRANCH && O_UOP_LATENCY == 7'h01)
		else $error("move not routed to branch unit with latency 1");
	AST_MOVE_EVERY_CYCLE: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		(state_reg == fxil_pkg::ST_IDLE && d_branch && src_a_ok && src_b_ok) |-> O_ISSUE_READY)
		else $error("branch move refused without hazard");
	AST_DEP_HOLD: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		(!src_a_ok || !src_b_ok) |-> !O_ISSUE_READY)
		else $error("dependent issued before producer latency elapsed");
	AST_DIV_FINISH: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		(div_start && !d_mc) |=> O_INT_BUSY [*8] ##1 (O_INT_BUSY && !O_DIV_DONE)
			##1 !O_DIV_DONE ##[1:61] O_DIV_DONE)
		else $error("divide finished outside its window");

	COV_REC_DIV: cover property (@(posedge I_REF_CLK) disable iff (I_RST)
		state_reg == fxil_pkg::ST_DIV && rec_reg && div_done);
	COV_CLZ_REC: cover property (@(posedge I_REF_CLK) disable iff (I_RST) accept && d_clz_rec);
	COV_MOVE_IN_DIV: cover property (@(posedge I_REF_CLK) disable iff (I_RST)
		accept && state_reg == fxil_pkg::ST_DIV);
	COV_SHIFT_STALL: cover property (@(posedge I_REF_CLK) disable iff (I_RST)
		I_ISSUE_VALID && d_shift && shift_gap_reg);

endmodule

// *** fxil_pkg.sv ***
// Shared constants and types for the integer issue-routing and latency control block
package fxil_pkg;

	// ==========================================================================
	// Widths
	localparam int OP_W     = 5;
	localparam int TAG_W    = 6;
	localparam int LAT_W    = 7;
	localparam int KIND_W   = 3;
	localparam int LEAD_W   = 7;
	localparam int NUM_TAGS = 35;

	// ==========================================================================
	// Opcode classes presented by the issue stage; signed and unsigned forms share a class
	localparam logic [OP_W-1:0] OP_COMPARE        = 5'h00;
	localparam logic [OP_W-1:0] OP_LOGICAL        = 5'h01;
	localparam logic [OP_W-1:0] OP_EXT_SIGN       = 5'h02;
	localparam logic [OP_W-1:0] OP_CLZ_WORD       = 5'h03;
	localparam logic [OP_W-1:0] OP_CLZ_DWORD      = 5'h04;
	localparam logic [OP_W-1:0] OP_ROTATE         = 5'h05;
	localparam logic [OP_W-1:0] OP_SRA_IMM_WORD   = 5'h06;
	localparam logic [OP_W-1:0] OP_SRA_IMM_DWORD  = 5'h07;
	localparam logic [OP_W-1:0] OP_MOVE_TO_RETURN = 5'h08;
	localparam logic [OP_W-1:0] OP_MOVE_TO_COUNT  = 5'h09;
	localparam logic [OP_W-1:0] OP_DIV_WORD       = 5'h0A;
	localparam logic [OP_W-1:0] OP_DIV_DWORD      = 5'h0B;
	localparam logic [OP_W-1:0] OP_DIVO_REC_WORD  = 5'h0C;
	localparam logic [OP_W-1:0] OP_DIVO_REC_DWORD = 5'h0D;
	localparam logic [OP_W-1:0] OP_CLZ_REC_WORD   = 5'h0E;
	localparam logic [OP_W-1:0] OP_CLZ_REC_DWORD  = 5'h0F;

	// ==========================================================================
	// Operation kinds sent to the execution units
	localparam logic [KIND_W-1:0] UOP_ALU     = 3'h0;
	localparam logic [KIND_W-1:0] UOP_SHIFT   = 3'h1;
	localparam logic [KIND_W-1:0] UOP_MOVE    = 3'h2;
	localparam logic [KIND_W-1:0] UOP_DIVIDE  = 3'h3;
	localparam logic [KIND_W-1:0] UOP_COMPARE = 3'h4;
	localparam logic [KIND_W-1:0] UOP_CLZ     = 3'h5;

	// ==========================================================================
	// Result tags above the general registers
	localparam logic [TAG_W-1:0] TAG_RETURN_ADDR = 6'h20;
	localparam logic [TAG_W-1:0] TAG_COUNT       = 6'h21;
	localparam logic [TAG_W-1:0] TAG_COND        = 6'h22;

	// ==========================================================================
	// Latencies in core cycles
	localparam logic [LAT_W-1:0] LAT_COMPARE = 7'h01;
	localparam logic [LAT_W-1:0] LAT_GPR     = 7'h02;
	localparam logic [LAT_W-1:0] LAT_MOVE    = 7'h01;
	localparam logic [LAT_W-1:0] LAT_PEND_RST = 7'h00;

	// Divide timing: ((setup + ceil(diff/2) + 1 + fixup) x 2), clamped
	localparam logic [7:0] DIV_SETUP     = 8'h01;
	localparam logic [7:0] DIV_ITER_XTRA = 8'h01;
	localparam logic [7:0] DIV_FIXUP     = 8'h01;
	localparam logic [7:0] DIV_SCALE     = 8'h02;
	localparam logic [7:0] DIV_MIN       = 8'h0A;
	localparam logic [7:0] DIV_WORD_MAX  = 8'h26;
	localparam logic [7:0] DIV_DWORD_MAX = 8'h46;

	typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_WAIT} fxil_state_t;

endpackage

// *** fxil_div_timer.sv ***
// Data-dependent divide cycle count and completion timer
module fxil_div_timer (
	input  wire logic                       i_clk,
	input  wire logic                       i_rst,
	input  wire logic                       i_start,
	input  wire logic                       i_dword,
	input  wire logic                       i_overflow,
	input  wire logic [fxil_pkg::LEAD_W-1:0] i_ra_lead,
	input  wire logic [fxil_pkg::LEAD_W-1:0] i_rb_lead,
	output logic      [fxil_pkg::LAT_W-1:0]  o_cycles,
	output logic                             o_busy,
	output logic                             o_done
);

	logic [fxil_pkg::LAT_W-1:0] cnt_reg;
	logic [fxil_pkg::LAT_W-1:0] cnt_next;
	logic [7:0]                 diff;
	logic [7:0]                 cyc;
	logic [7:0]                 cyc_max;

	// ==========================================================================
	// Cycle count
	always_comb begin
		diff = (i_rb_lead > i_ra_lead) ? 8'({1'b0, i_rb_lead} - {1'b0, i_ra_lead}) : 8'h00;
		cyc = 8'((fxil_pkg::DIV_SETUP + 8'((diff + 8'h01) >> 1) + fxil_pkg::DIV_ITER_XTRA
			+ fxil_pkg::DIV_FIXUP) * fxil_pkg::DIV_SCALE);
		cyc_max = i_dword ? fxil_pkg::DIV_DWORD_MAX : fxil_pkg::DIV_WORD_MAX;
		if (i_overflow) begin
			cyc = fxil_pkg::DIV_MIN;
		end else if (cyc < fxil_pkg::DIV_MIN) begin
			cyc = fxil_pkg::DIV_MIN;
		end else if (cyc > cyc_max) begin
			cyc = cyc_max;
		end
		o_cycles = 7'(cyc);
	end

	// ==========================================================================
	// Countdown; done fires exactly o_cycles edges after start
	always_comb begin
		cnt_next = cnt_reg;
		if (i_start) begin
			cnt_next = o_cycles;
		end else if (cnt_reg != 7'h00) begin
			cnt_next = cnt_reg - 7'h01;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_reg <= 7'h00;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign o_busy = (cnt_reg != 7'h00);
	assign o_done = (cnt_reg == 7'h01);

	// ==========================================================================
	// Checks
	AST_DIV_RANGE: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_start && !i_overflow) |-> (o_cycles >= 7'h0A) && (o_cycles <= (i_dword ? 7'h46 : 7'h26)))
		else $error("divide cycle count out of range");
	AST_DIV_OVF_TEN: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_start && i_overflow) |-> ##10 o_done)
		else $error("overflow divide did not finish in 10 cycles");

endmodule

// *** fxil_issue_model.sv ***
// Issue-stage model that offers one operation at a time to the issue control block
module fxil_issue_model (
	input  wire logic                      i_clk,
	input  wire logic                      i_ready,
	output logic                           o_valid,
	output logic [fxil_pkg::OP_W-1:0]      o_op,
	output logic [fxil_pkg::TAG_W-1:0]     o_dest,
	output logic [fxil_pkg::TAG_W-1:0]     o_src_a,
	output logic [fxil_pkg::TAG_W-1:0]     o_src_b,
	output logic [fxil_pkg::LEAD_W-1:0]    o_ra_lead,
	output logic [fxil_pkg::LEAD_W-1:0]    o_rb_lead,
	output logic                           o_ovf
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================================
	// Idle request lines
	initial begin
		o_valid   = 1'b0;
		o_op      = 5'h00;
		o_dest    = 6'h00;
		o_src_a   = 6'h3F;
		o_src_b   = 6'h3F;
		o_ra_lead = 7'h00;
		o_rb_lead = 7'h00;
		o_ovf     = 1'b0;
	end

	// ==========================================================================
	// Offer: driven after a falling edge, held until a rising edge sees ready
	task automatic offer(input logic [4:0] op, input logic [5:0] dest, input logic [5:0] src,
		input logic [6:0] ra, input logic [6:0] rb, input logic ovf, input int bound,
		output bit ok);
		ok = 1'b0;
		@(negedge i_clk);
		o_valid   = 1'b1;
		o_op      = op;
		o_dest    = dest;
		o_src_a   = src;
		o_ra_lead = ra;
		o_rb_lead = rb;
		o_ovf     = ovf;
		for (int n = 0; n < bound && !ok; n++) begin
			#1;
			ok = (i_ready === 1'b1);
			if (!ok) begin
				@(negedge i_clk);
			end
		end
		@(posedge i_clk);
		#1;
	endtask

	// Released lines flip so a stale value can never be mistaken for a live one
	task automatic release_req();
		@(negedge i_clk);
		o_valid   = 1'b0;
		o_op      = ~o_op;
		o_dest    = ~o_dest;
		o_src_a   = ~o_src_a;
		o_ra_lead = ~o_ra_lead;
		o_rb_lead = ~o_rb_lead;
		o_ovf     = ~o_ovf;
	endtask
endmodule

// *** fxil_issue_ctrl_tb.sv ***
// Self-checking testbench for the integer issue-routing and latency block
module fxil_issue_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic                         ref_clk;
	logic                         rst;
	logic                         valid;
	logic                         ready;
	logic [fxil_pkg::OP_W-1:0]    op;
	logic [fxil_pkg::TAG_W-1:0]   dest;
	logic [fxil_pkg::TAG_W-1:0]   src_a;
	logic [fxil_pkg::TAG_W-1:0]   src_b;
	logic [fxil_pkg::LEAD_W-1:0]  ra;
	logic [fxil_pkg::LEAD_W-1:0]  rb;
	logic                         ovf;
	logic                         uv;
	logic [fxil_pkg::KIND_W-1:0]  kind;
	logic                         br;
	logic [fxil_pkg::TAG_W-1:0]   udest;
	logic [fxil_pkg::LAT_W-1:0]   ulat;
	logic                         mc;
	logic                         pipe;
	logic                         busy;
	logic                         done;
	int                           error_cnt;
	int                           checks_done;
	int                           cyc;
	int                           q_cyc[$];
	logic [18:0]                  q_uop[$];
	logic                         busy_at[4096];
	logic                         done_at[4096];

	fxil_issue_ctrl fxil_issue_ctrl_i (.I_REF_CLK(ref_clk), .I_RST(rst), .I_ISSUE_VALID(valid),
		.I_ISSUE_OP(op), .I_ISSUE_DEST(dest), .I_ISSUE_SRC_A(src_a), .I_ISSUE_SRC_B(src_b),
		.I_DIV_RA_LEAD(ra), .I_DIV_RB_LEAD(rb), .I_DIV_OVERFLOW(ovf), .O_ISSUE_READY(ready),
		.O_UOP_VALID(uv), .O_UOP_KIND(kind), .O_UOP_TO_BRANCH(br), .O_UOP_DEST(udest),
		.O_UOP_LATENCY(ulat), .O_MICROCODED_FLAG(mc), .O_PIPELINED(pipe), .O_INT_BUSY(busy),
		.O_DIV_DONE(done));

	fxil_issue_model fxil_issue_model_i (.i_clk(ref_clk), .i_ready(ready), .o_valid(valid),
		.o_op(op), .o_dest(dest), .o_src_a(src_a), .o_src_b(src_b), .o_ra_lead(ra),
		.o_rb_lead(rb), .o_ovf(ovf));

	// ==========================================================================
	// Clock, cycle count and output monitor
	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) cyc <= cyc + 1;
	always @(negedge ref_clk) begin
		busy_at[cyc % 4096] = busy;
		done_at[cyc % 4096] = done;
		if (uv === 1'b1) begin
			q_cyc.push_back(cyc);
			q_uop.push_back({kind, br, udest, ulat, mc, pipe});
		end
	end

	// ==========================================================================
	// Compare and issue helpers
	task automatic chk(input string name, input logic [18:0] exp, input logic [18:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_uop(input string name, input int at, input logic [2:0] k,
		input logic b, input logic [5:0] d, input logic [6:0] l, input logic m);
		if (q_cyc.size() == 0) begin
			chk(name, 19'h1, 19'h0);
		end else begin
			chk(name, 19'(at), 19'(q_cyc.pop_front()));
			chk(name, {k, b, d, l, m, k !== fxil_pkg::UOP_DIVIDE}, q_uop.pop_front());
		end
	endtask

	task automatic issue(input logic [4:0] o, input logic [5:0] d, input logic [5:0] s,
		input logic [6:0] a, input logic [6:0] b, input logic v, output int stamp);
		bit ok;
		fxil_issue_model_i.offer(o, d, s, a, b, v, 100, ok);
		stamp = cyc;
		if (!ok) begin
			error_cnt++;
			$display("MISMATCH issue of op %h expected taken seen refused", o);
			give_verdict();
		end
	endtask

	task automatic give_verdict();
		$display("Counts: %0d checks, %0d errors", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ==========================================================================
	// Scenarios
	task automatic test_moves();
		int s0, s1, s2;
		bit ok;
		issue(fxil_pkg::OP_MOVE_TO_RETURN, 6'h20, 6'h3F, 7'h00, 7'h00, 1'b0, s0);
		issue(fxil_pkg::OP_MOVE_TO_COUNT, 6'h21, 6'h20, 7'h00, 7'h00, 1'b0, s1);
		issue(fxil_pkg::OP_MOVE_TO_RETURN, 6'h20, 6'h21, 7'h00, 7'h00, 1'b0, s2);
		fxil_issue_model_i.release_req();
		#1;
		chk("move spacing", {1'b1, 18'(s0 + 2)}, {s1 == s0 + 1, 18'(s2)});
		chk_uop("move ret", s0, fxil_pkg::UOP_MOVE, 1'b1, 6'h20, 7'h01, 1'b0);
		chk_uop("move cnt", s1, fxil_pkg::UOP_MOVE, 1'b1, 6'h21, 7'h01, 1'b0);
		chk_uop("move ret2", s2, fxil_pkg::UOP_MOVE, 1'b1, 6'h20, 7'h01, 1'b0);
		fxil_issue_model_i.offer(5'h10, 6'h01, 6'h3F, 7'h00, 7'h00, 1'b0, 6, ok);
		fxil_issue_model_i.release_req();
		chk("unknown op taken", 19'h0, 19'(ok));
	endtask

	task automatic test_shifts();
		int s0, s1, s2, s3;
		issue(fxil_pkg::OP_SRA_IMM_WORD, 6'h03, 6'h3F, 7'h00, 7'h00, 1'b0, s0);
		issue(fxil_pkg::OP_SRA_IMM_DWORD, 6'h04, 6'h3F, 7'h00, 7'h00, 1'b0, s1);
		issue(fxil_pkg::OP_LOGICAL, 6'h06, 6'h04, 7'h00, 7'h00, 1'b0, s2);
		issue(fxil_pkg::OP_CLZ_WORD, 6'h07, 6'h3F, 7'h00, 7'h00, 1'b0, s3);
		fxil_issue_model_i.release_req();
		#1;
		chk("shift pacing", 19'(s0 + 2), 19'(s1));
		chk("dependent wait", 19'(s1 + 2), 19'(s2));
		chk("independent", 19'(s2 + 1), 19'(s3));
		chk_uop("sra word", s0, fxil_pkg::UOP_SHIFT, 1'b0, 6'h03, 7'h02, 1'b0);
		chk_uop("sra dword", s1, fxil_pkg::UOP_SHIFT, 1'b0, 6'h04, 7'h02, 1'b0);
		chk_uop("logical", s2, fxil_pkg::UOP_ALU, 1'b0, 6'h06, 7'h02, 1'b0);
		chk_uop("clz plain", s3, fxil_pkg::UOP_CLZ, 1'b0, 6'h07, 7'h02, 1'b0);
	endtask

	task automatic test_div_rec();
		logic [4:0] op_t[5] = '{5'h0C, 5'h0C, 5'h0C, 5'h0D, 5'h0D};
		logic [6:0] ra_t[5] = '{7'h00, 7'h00, 7'h05, 7'h00, 7'h03};
		logic [6:0] rb_t[5] = '{7'h3C, 7'h40, 7'h05, 7'h64, 7'h0C};
		logic       ov_t[5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
		int         lt[5] = '{10, 38, 10, 70, 16};
		int         a, m;
		for (int k = 0; k < 5; k++) begin
			issue(op_t[k], 6'h05, 6'h3F, ra_t[k], rb_t[k], ov_t[k], a);
			issue(fxil_pkg::OP_MOVE_TO_COUNT, 6'h21, 6'h3F, 7'h00, 7'h00, 1'b0, m);
			fxil_issue_model_i.release_req();
			#1;
			chk("held off", 19'h1, 19'(m >= a + lt[k] + 1));
			chk_uop("div", a, fxil_pkg::UOP_DIVIDE, 1'b0, 6'h05, 7'(lt[k]), 1'b1);
			chk_uop("div cmp", a + lt[k], fxil_pkg::UOP_COMPARE, 1'b0, 6'h22, 7'h01, 1'b1);
			chk_uop("move after", m, fxil_pkg::UOP_MOVE, 1'b1, 6'h21, 7'h01, 1'b0);
			chk("busy", 19'h6, 19'({busy_at[a], busy_at[a + lt[k] - 1], busy_at[a + lt[k]]}));
			chk("done", 19'h1, 19'({done_at[a + lt[k] - 1], done_at[a + lt[k]]}));
		end
	endtask

	task automatic test_div_plain();
		int a, m, l;
		issue(fxil_pkg::OP_DIV_WORD, 6'h08, 6'h3F, 7'h03, 7'h0C, 1'b0, a);
		issue(fxil_pkg::OP_MOVE_TO_RETURN, 6'h20, 6'h3F, 7'h00, 7'h00, 1'b0, m);
		issue(fxil_pkg::OP_LOGICAL, 6'h0A, 6'h08, 7'h00, 7'h00, 1'b0, l);
		fxil_issue_model_i.release_req();
		#1;
		chk("branch move", 19'(a + 1), 19'(m));
		chk("int blocked", 19'h1, 19'(l >= a + 16));
		chk_uop("plain div", a, fxil_pkg::UOP_DIVIDE, 1'b0, 6'h08, 7'h10, 1'b0);
		chk_uop("move in div", m, fxil_pkg::UOP_MOVE, 1'b1, 6'h20, 7'h01, 1'b0);
		chk_uop("logical", l, fxil_pkg::UOP_ALU, 1'b0, 6'h0A, 7'h02, 1'b0);
	endtask

	task automatic test_clz_rec();
		int a, m;
		for (int k = 0; k < 2; k++) begin
			issue(5'(fxil_pkg::OP_CLZ_REC_WORD + k), 6'h09, 6'h3F, 7'h00, 7'h00, 1'b0, a);
			issue(fxil_pkg::OP_MOVE_TO_COUNT, 6'h21, 6'h3F, 7'h00, 7'h00, 1'b0, m);
			fxil_issue_model_i.release_req();
			#1;
			chk("clz seq blocks", 19'h1, 19'(m >= a + 3));
			chk("clz busy", 19'h1, 19'(busy_at[a]));
			chk_uop("clz rec", a, fxil_pkg::UOP_CLZ, 1'b0, 6'h09, 7'h02, 1'b1);
			chk_uop("clz cmp", a + 2, fxil_pkg::UOP_COMPARE, 1'b0, 6'h22, 7'h01, 1'b1);
			chk_uop("move after", m, fxil_pkg::UOP_MOVE, 1'b1, 6'h21, 7'h01, 1'b0);
		end
	endtask

	// ==========================================================================
	// Main sequence
	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		cyc = 0;
		error_cnt = 0;
		checks_done = 0;
		repeat (12) @(negedge ref_clk);
		rst = 1'b0;
		#1;
		chk("after reset", 19'h1, 19'({uv, busy, ready}));
		test_moves();
		test_shifts();
		test_div_rec();
		test_div_plain();
		test_clz_rec();
		give_verdict();
	end
endmodule
